// ---- src/led_bar_defines.vh ----
/*
 Constants for the five-stage LED bar shift register.
 Assumes inclusion by the design files under src/ only.
*/
`ifndef LED_BAR_DEFINES_VH
`define LED_BAR_DEFINES_VH

// ------------------------------------------------------------
// Bar geometry, reset value and bit FIFO size
// ------------------------------------------------------------
`define LED_BAR_WIDTH 5
`define LED_BAR_RESET_VALUE 5'h00
`define LED_BAR_FIFO_DEPTH 8
`define LED_BAR_FIFO_AW 3

// ------------------------------------------------------------
// Synchroniser clear values
// ------------------------------------------------------------
`define LED_BAR_SYNC_ACTIVE 2'h0
`define LED_BAR_SYNC_IDLE 2'h3

`endif

// ---- src/led_bar_fifo.v ----
/*
 Holds no logic: the bit FIFO module led_bar_fifo sits beside the bar
 logic in led_bar_shift_register.v, so one design file carries it all.
 Assumes nothing of its surroundings.
*/

// ---- src/led_bar_shift_register.v ----
/*
 Five-stage serial-in shift register driving an active-low LED bar,
 together with the small bit FIFO that sits between pin edge and bar.
 Assumes the host drives bar reset, shift clock and data as plain pins
 with no timing relation to clk_sys, and holds each shift clock phase
 for at least two clk_sys periods.
*/
// Function
// - Reset low forces all five outputs low, lighting every LED.
// - Each shift clock rising edge with reset high samples data into the first stage; edges during reset are dropped.
// - Low output lights its LED; host sends low for on, high for off.
// - New bit appears at LED 5; others move toward LED 1, LED 1 dropped.
`timescale 1ns/1ps
`include "led_bar_defines.vh"

// ------------------------------------------------------------
// Bit FIFO, valid/ready on both sides
// ------------------------------------------------------------
module led_bar_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = `LED_BAR_FIFO_DEPTH,
   parameter AW = `LED_BAR_FIFO_AW
) (
   input wire clk_sys,
   input wire reset_n,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg [AW-1:0] wr_ptr_next;
   reg [AW-1:0] rd_ptr_next;
   reg [AW:0] count_next;
   wire push;
   wire pop;

   // Wraps at DEPTH, so depths other than powers of two work
   function [AW-1:0] ptr_inc;
      input [AW-1:0] p;
      begin
         if (p == DEPTH - 1)
            ptr_inc = {AW{1'b0}};
         else
            ptr_inc = p + 1'b1;
      end
   endfunction

   assign in_ready = (count_reg != DEPTH);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @* begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next = count_reg;
      if (push)
         wr_ptr_next = ptr_inc(wr_ptr_reg);
      if (pop)
         rd_ptr_next = ptr_inc(rd_ptr_reg);
      if (push && !pop)
         count_next = count_reg + 1'b1;
      else if (pop && !push)
         count_next = count_reg - 1'b1;
   end

   // Storage has no reset; only the count_reg words from rd_ptr_reg on are ever popped
   always @(posedge clk_sys) begin
      if (push)
         mem[wr_ptr_reg] <= in_data;
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end
endmodule // led_bar_fifo

// ------------------------------------------------------------
// LED bar shift register
// ------------------------------------------------------------
module led_bar_shift_register #(
   parameter WIDTH = `LED_BAR_WIDTH,
   parameter FIFO_DEPTH = `LED_BAR_FIFO_DEPTH
) (
   input wire clk_sys,
   input wire reset_n,
   input wire led_bar_reset_line,
   input wire led_bar_shift_clock_line,
   input wire led_bar_data_line,
   output reg [WIDTH-1:0] led_bar_n,
   output reg fifo_overflow
);

   // Address bits for a FIFO of the given depth
   function integer addr_bits;
      input integer depth;
      integer n;
      begin
         addr_bits = 1;
         for (n = 2; n < depth; n = n * 2)
            addr_bits = addr_bits + 1;
      end
   endfunction

   // One step of the bar: new bit enters the LED 5 end
   function [WIDTH-1:0] shift_in;
      input [WIDTH-1:0] bar;
      input bit_in;
      begin
         shift_in = {bit_in, bar[WIDTH-1:1]};
      end
   endfunction

   localparam FIFO_AW = addr_bits(FIFO_DEPTH);
   localparam [WIDTH-1:0] BAR_RESET = `LED_BAR_RESET_VALUE;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   reg [1:0] rst_sync_reg;
   reg [1:0] clk_sync_reg;
   reg [1:0] dat_sync_reg;
   reg clk_prev_reg;
   wire bar_rst_n;
   wire bar_clear;
   wire shift_rise;
   wire shift_take;
   wire overflow_event;
   wire fifo_in_ready;
   wire fifo_out_data;
   wire fifo_out_valid;
   wire fifo_out_ready;
   reg [WIDTH-1:0] led_bar_next;
   reg fifo_overflow_next;

   // Bar reset chain clears to active, so the bar is lit after power-up
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         rst_sync_reg <= `LED_BAR_SYNC_ACTIVE;
      else
         rst_sync_reg <= {rst_sync_reg[0], led_bar_reset_line};
   end

   // Clock chain and edge history clear to the idle high level
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         clk_sync_reg <= `LED_BAR_SYNC_IDLE;
         clk_prev_reg <= 1'b1;
      end else begin
         clk_sync_reg <= {clk_sync_reg[0], led_bar_shift_clock_line};
         clk_prev_reg <= clk_sync_reg[1];
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         dat_sync_reg <= `LED_BAR_SYNC_IDLE;
      else
         dat_sync_reg <= {dat_sync_reg[0], led_bar_data_line};
   end

   assign bar_rst_n = rst_sync_reg[1];
   assign bar_clear = !bar_rst_n;
   assign shift_rise = clk_sync_reg[1] && !clk_prev_reg;
   // Edges seen while the bar is held in reset are dropped
   assign shift_take = shift_rise && bar_rst_n;
   assign overflow_event = shift_take && !fifo_in_ready;
   // Drains every cycle; bits popped during bar reset are discarded
   assign fifo_out_ready = 1'b1;

   // ------------------------------------------------------------
   // Bit buffer between pin edge and the bar
   // ------------------------------------------------------------
   led_bar_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) bit_fifo (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .in_data(dat_sync_reg[1]),
      .in_valid(shift_take),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready)
   );

   // ------------------------------------------------------------
   // Next bar value and overflow flag
   // ------------------------------------------------------------
   always @* begin
      led_bar_next = led_bar_n;
      fifo_overflow_next = fifo_overflow;
      if (bar_clear) begin
         led_bar_next = BAR_RESET;
         fifo_overflow_next = 1'b0;
      end else begin
         if (fifo_out_valid)
            led_bar_next = shift_in(led_bar_n, fifo_out_data);
         // Never meets the clear: an overflow needs bar reset released
         if (overflow_event)
            fifo_overflow_next = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         led_bar_n <= BAR_RESET;
         fifo_overflow <= 1'b0;
      end else begin
         led_bar_n <= led_bar_next;
         fifo_overflow <= fifo_overflow_next;
      end
   end
endmodule // led_bar_shift_register

// ---- verif/led_bar_monitor.sv ----
/* Checker on the LED bar ports.
   Assumes binding to led_bar_shift_register. */
`timescale 1ns/1ps
module led_bar_monitor #(parameter WIDTH = 5) (
   input wire clk_sys,
   input wire reset_n,
   input wire led_bar_reset_line,
   input wire led_bar_shift_clock_line,
   input wire led_bar_data_line,
   input wire [WIDTH-1:0] led_bar_n,
   input wire fifo_overflow
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire rl = led_bar_reset_line;
   sequence sh; $rose(led_bar_shift_clock_line) && rl; endsequence
   property p_top; logic d;
      (sh, d = led_bar_data_line) ##1 rl [*4] |-> led_bar_n[WIDTH-1] == d; endproperty
   property p_move; logic [WIDTH-1:0] v;
      (sh, v = led_bar_n) ##1 rl [*4] |-> led_bar_n[WIDTH-2:0] == v[WIDTH-1:1]; endproperty
   a_reset_lit: assert property (!rl [*4] |-> led_bar_n == 0)
      else $error("bar not lit");
   a_new_bit: assert property (p_top)
      else $error("new bit lost");
   a_low_lit: assert property (sh ##0 !led_bar_data_line ##1 rl [*4]
      |-> !led_bar_n[WIDTH-1])
      else $error("low bit not lit");
   a_bits_move: assert property (p_move)
      else $error("bits not moved");
   a_reset_hold: assert property (!rl [*5] |-> $stable(led_bar_n))
      else $error("bar changed in reset");
   c_shift: cover property (sh);
   c_bar_reset: cover property ($fell(rl));
   c_all_off: cover property (&led_bar_n);
endmodule // led_bar_monitor
bind led_bar_shift_register led_bar_monitor #(.WIDTH(WIDTH)) mon_u (.clk_sys, .reset_n,
   .led_bar_reset_line, .led_bar_shift_clock_line, .led_bar_data_line, .led_bar_n,
   .fifo_overflow);

// ---- verif/led_bar_host.sv ----
/* Host model driving the bar pins.
   Assumes calls from the bench; pins change at clk_sys falling edges. */
`timescale 1ns/1ps
module led_bar_host (
   input wire clk_sys,
   output logic led_bar_reset_line = 1,
   output logic led_bar_shift_clock_line = 1,
   output logic led_bar_data_line = 1
);
   task automatic bar(input logic v);
      @(negedge clk_sys);
      led_bar_reset_line = v;
   endtask
   // Clock idles high, data set while low, 200 ns cycle
   task automatic shift(input logic b);
      repeat (4) @(negedge clk_sys);
      led_bar_shift_clock_line = 0;
      led_bar_data_line = b;
      repeat (4) @(negedge clk_sys);
      led_bar_shift_clock_line = 1;
   endtask
   task automatic send(input logic [4:0] p);
      for (int i = 0; i < 5; i++) shift(p[i]);
   endtask
endmodule // led_bar_host

// ---- verif/tb_led_bar_shift_register.sv ----
/* Bench for led_bar_shift_register.
   Assumes led_bar_host and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h", $time, a); end end
module tb_led_bar_shift_register;
   logic clk_sys = 0;
   logic reset_n = 0;
   wire led_bar_reset_line, led_bar_shift_clock_line, led_bar_data_line;
   wire [4:0] led_bar_n;
   wire fifo_overflow;
   int miscompares = 0;
   int total_checks = 0;
   always #12.5 clk_sys = ~clk_sys;
   led_bar_host host_u (.clk_sys, .led_bar_reset_line, .led_bar_shift_clock_line,
      .led_bar_data_line);
   led_bar_shift_register dut_u (.clk_sys, .reset_n, .led_bar_reset_line,
      .led_bar_shift_clock_line, .led_bar_data_line, .led_bar_n, .fifo_overflow);
   task automatic finish_test;
      $display("miscompares %0d total_checks %0d", miscompares, total_checks);
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_patterns;
      logic [4:0] p [4] = '{5'h14, 5'h0b, 5'h00, 5'h1f};
      foreach (p[i]) begin
         host_u.send(p[i]);
         repeat (6) @(negedge clk_sys);
         `CHK(led_bar_n, p[i])
      end
   endtask
   task automatic t_bar_reset;
      host_u.bar(1'b0);
      host_u.send(5'h1f);
      `CHK(led_bar_n, 5'h00)
      host_u.bar(1'b1);
      repeat (4) @(negedge clk_sys);
      host_u.shift(1'b1);
      repeat (6) @(negedge clk_sys);
      `CHK(led_bar_n, 5'h10)
      `CHK(fifo_overflow, 1'b0)
   endtask
   initial begin
      repeat (3) @(negedge clk_sys);
      reset_n = 1;
      repeat (4) @(negedge clk_sys);
      t_patterns;
      t_bar_reset;
      finish_test;
   end
   initial begin
      #100000;
      miscompares++;
      finish_test;
   end
endmodule // tb_led_bar_shift_register
